/* File: emx_pkg.sv */
// shared constants and opcode set of the execute unit
package emx_pkg;
    localparam int FLAG_C = 0;
    localparam int FLAG_AC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_PD = 4;
    localparam int FLAG_TO = 5;
    localparam int FLAG_W = 6;
    localparam logic [5:0] FLAGS_RST = 6'h00;
    localparam int MEM_ADDR_W = 7;
    localparam int MEM_WORDS = 128;
    localparam int IMM_W = 8;
    localparam int PC_W = 11;
    localparam logic [10:0] PC_RST = 11'h000;
    localparam int STACK_DEPTH = 4;
    localparam int DOG_LIMIT = 1024;
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [3:0] BCD_FIX = 4'h6;
    localparam logic [11:0] REG_STATUS = 12'h000;
    localparam logic [11:0] REG_WORK = 12'h004;
    localparam logic [11:0] REG_PC = 12'h008;
    localparam logic [11:0] REG_CTRL = 12'h00c;
    localparam logic [11:0] REG_DOG = 12'h010;
    localparam logic [3:0] MEM_WIN = 4'h1;
    localparam int CTRL_WAKE = 0;
    localparam int STAT_RUN = 8;
    localparam int STAT_PRE1 = 9;
    localparam int STAT_PRE2 = 10;

    typedef enum logic [4:0] {
        OP_NOP,
        OP_ADD_MEM,
        OP_ADD_IMM,
        OP_ADD_TO_BYTE,
        OP_ADC_MEM,
        OP_ADC_TO_BYTE,
        OP_AND_MEM,
        OP_AND_IMM,
        OP_AND_TO_BYTE,
        OP_INVERT_BYTE,
        OP_INVERT_TO_WORK,
        OP_DECIMAL_ADJUST,
        OP_DEC_BYTE,
        OP_DEC_TO_WORK,
        OP_CALL,
        OP_CLR_BYTE,
        OP_CLR_BIT,
        OP_DOG_CLEAR,
        OP_DOG_PRECLEAR_FIRST,
        OP_DOG_PRECLEAR_SECOND,
        OP_HALT
    } emx_op_e;
endpackage : emx_pkg

/* File: emx_exec.sv */
// execute unit: adds, logic, complement, decrement, bcd adjust, clears, call, dog, halt
//
// Notes on behaviour
// (RULE1) carry add into work register: work + byte + carry; OV, Z, AC, C update
// (RULE2) carry add into byte: same three-way sum stored in byte; OV, Z, AC, C
// (RULE3) plain adds ignore carry, store to named destination; OV, Z, AC, C update
// (RULE4) AND of work with byte or immediate; only Z changes
// (RULE5) call pushes pc plus one, then loads target; no flag changes
// (RULE6) byte clear writes zero; flags untouched
// (RULE7) bit clear zeroes one selected bit only; flags untouched
// (RULE8) dog clear resets timer and clears sleep and expired flags
// (RULE9) preclear clears only if other preclear already ran; else just records itself
// (RULE10) invert byte in place; only Z changes
// (RULE11) invert byte into work register; byte kept; only Z changes
// (RULE12) bcd adjust low nibble: add 6 if above 9 or AC; makes nibble carry
// (RULE13) bcd adjust high nibble: add spill, add 6 and set C if above 9 or C
// (RULE14) bcd adjust result goes to byte; only C may change
// (RULE15) decrement byte in place; only Z changes
// (RULE16) decrement byte into work register; byte kept; only Z changes
// (RULE17) halt stops execution, keeps memory and registers
// (RULE18) halt resets dog timer, sets sleep flag, clears expired flag
// (RULE19) byte operands addressed by a 7-bit field
// (RULE20) call target is 11 bits; immediates are 8 bits
// (RULE21) flags not affected by an instruction keep their value
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module emx_exec
    import emx_pkg::*;
#(
    parameter int MEM_N = MEM_WORDS,
    parameter int STACK_N = STACK_DEPTH,
    parameter int DOG_N = DOG_LIMIT
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic instr_valid_i,
    input wire emx_op_e instr_op_i,
    input wire logic [MEM_ADDR_W-1:0] instr_addr_i,
    input wire logic [IMM_W-1:0] instr_imm_i,
    input wire logic [2:0] instr_bit_i,
    input wire logic [PC_W-1:0] instr_target_i,
    output logic instr_ready_o,
    output logic [7:0] work_register_o,
    output logic [FLAG_W-1:0] flags_o,
    output logic [PC_W-1:0] pc_o,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic pready_o,
    output logic pslverr_o,
    output logic [31:0] prdata_o
);
    localparam int SP_W = (STACK_N > 1) ? $clog2(STACK_N) : 1;
    localparam int DOG_W = $clog2(DOG_N + 1);
    localparam logic [DOG_W-1:0] DOG_LAST = DOG_W'(DOG_N - 1);

    typedef struct packed {
        logic [MEM_N-1:0][7:0] mem;
        logic [STACK_N-1:0][PC_W-1:0] stack;
        logic [SP_W-1:0] sp;
        logic [PC_W-1:0] pc;
        logic [7:0] work;
        logic [FLAG_W-1:0] flags;
        logic run;
        logic pre1;
        logic pre2;
        logic [DOG_W-1:0] dog;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } emx_state_s;

    emx_state_s st;
    emx_state_s next_st;

    // returns {ov, half carry, carry, sum}
    function automatic logic [10:0] emx_add(input logic [7:0] a, input logic [7:0] b,
                                            input logic cin);
        logic [8:0] s;
        logic [4:0] h;
        logic ov;
        s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        ov = (a[7] == b[7]) && (s[7] != a[7]);
        return {ov, h[4], s[8], s[7:0]};
    endfunction : emx_add

    function automatic logic [FLAG_W-1:0] emx_zero(input logic [FLAG_W-1:0] f,
                                                   input logic [7:0] r);
        logic [FLAG_W-1:0] o;
        o = f;
        o[FLAG_Z] = (r == 8'h00);
        return o;
    endfunction : emx_zero

    logic fire;
    logic [7:0] mem_rd;
    logic dog_expire;
    logic [10:0] sum;
    logic [4:0] lo_sum;
    logic [4:0] hi_sum;
    logic low_nibble_bcd_spill;

    assign fire = instr_valid_i && st.run;
    assign mem_rd = st.mem[instr_addr_i]; // RULE19
    assign dog_expire = (st.dog == DOG_LAST);

    always_comb begin
        next_st = st;
        sum = 11'h000;
        lo_sum = 5'h00;
        hi_sum = 5'h00;
        low_nibble_bcd_spill = 1'b0;
        // apb slave: one wait state, answer registered
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;
        next_st.prdata = 32'h0000_0000;
        if (psel_i && penable_i && !st.pready) begin
            next_st.pready = 1'b1;
            if (paddr_i[11:8] == MEM_WIN && paddr_i[1:0] == 2'b00
                && {1'b0, paddr_i[7:2]} < MEM_ADDR_W'(MEM_N / 2)) begin
                next_st.prdata = {24'h000000, st.mem[{1'b0, paddr_i[7:2]}]};
            end else begin
                unique case (paddr_i)
                    REG_STATUS: begin
                        next_st.prdata = {21'h000000, st.pre2, st.pre1, st.run,
                                          2'b00, st.flags};
                    end
                    REG_WORK: next_st.prdata = {24'h000000, st.work};
                    REG_PC: next_st.prdata = {21'h000000, st.pc};
                    REG_CTRL: next_st.prdata = 32'h0000_0000;
                    REG_DOG: next_st.prdata = 32'(st.dog);
                    default: next_st.pslverr = 1'b1;
                endcase
            end
        end
        if (psel_i && penable_i && st.pready && pwrite_i && paddr_i == REG_CTRL
            && pwdata_i[CTRL_WAKE]) begin
            next_st.run = 1'b1;
        end
        next_st.dog = st.dog + DOG_W'(1);
        // unlisted flags fall through from next_st = st
        if (fire) begin // RULE21
            next_st.pc = st.pc + PC_W'(1);
            unique case (instr_op_i)
                OP_ADD_MEM, OP_ADD_IMM, OP_ADD_TO_BYTE, OP_ADC_MEM, OP_ADC_TO_BYTE: begin
                    sum = emx_add(st.work,
                                  (instr_op_i == OP_ADD_IMM) ? instr_imm_i : mem_rd, // RULE20
                                  (instr_op_i == OP_ADC_MEM || instr_op_i == OP_ADC_TO_BYTE)
                                      && st.flags[FLAG_C]); // RULE1 RULE2 RULE3
                    next_st.flags[FLAG_OV] = sum[10];
                    next_st.flags[FLAG_AC] = sum[9];
                    next_st.flags[FLAG_C] = sum[8];
                    next_st.flags[FLAG_Z] = (sum[7:0] == 8'h00);
                    if (instr_op_i == OP_ADD_TO_BYTE || instr_op_i == OP_ADC_TO_BYTE) begin
                        next_st.mem[instr_addr_i] = sum[7:0]; // RULE2 RULE3
                    end else begin
                        next_st.work = sum[7:0]; // RULE1 RULE3
                    end
                end
                OP_AND_MEM, OP_AND_IMM: begin
                    sum[7:0] = st.work & ((instr_op_i == OP_AND_IMM) ? instr_imm_i : mem_rd);
                    next_st.work = sum[7:0]; // RULE4
                    next_st.flags = emx_zero(st.flags, sum[7:0]); // RULE4
                end
                OP_AND_TO_BYTE: begin
                    sum[7:0] = st.work & mem_rd;
                    next_st.mem[instr_addr_i] = sum[7:0]; // RULE4
                    next_st.flags = emx_zero(st.flags, sum[7:0]);
                end
                OP_INVERT_BYTE: begin
                    next_st.mem[instr_addr_i] = ~mem_rd; // RULE10
                    next_st.flags = emx_zero(st.flags, ~mem_rd); // RULE10
                end
                OP_INVERT_TO_WORK: begin
                    next_st.work = ~mem_rd; // RULE11
                    next_st.flags = emx_zero(st.flags, ~mem_rd); // RULE11
                end
                OP_DEC_BYTE: begin
                    sum[7:0] = mem_rd - 8'h01;
                    next_st.mem[instr_addr_i] = sum[7:0]; // RULE15
                    next_st.flags = emx_zero(st.flags, sum[7:0]); // RULE15
                end
                OP_DEC_TO_WORK: begin
                    sum[7:0] = mem_rd - 8'h01;
                    next_st.work = sum[7:0]; // RULE16
                    next_st.flags = emx_zero(st.flags, sum[7:0]); // RULE16
                end
                OP_DECIMAL_ADJUST: begin
                    lo_sum = {1'b0, st.work[3:0]};
                    if (st.work[3:0] > BCD_MAX || st.flags[FLAG_AC]) begin
                        lo_sum = {1'b0, st.work[3:0]} + {1'b0, BCD_FIX}; // RULE12
                    end
                    low_nibble_bcd_spill = lo_sum[4]; // RULE12
                    hi_sum = {1'b0, st.work[7:4]} + {4'h0, low_nibble_bcd_spill}; // RULE13
                    if (hi_sum > {1'b0, BCD_MAX} || st.flags[FLAG_C]) begin
                        hi_sum = hi_sum + {1'b0, BCD_FIX}; // RULE13
                        next_st.flags[FLAG_C] = 1'b1; // RULE13 RULE14
                    end
                    next_st.mem[instr_addr_i] = {hi_sum[3:0], lo_sum[3:0]}; // RULE14
                end
                OP_CALL: begin
                    next_st.stack[st.sp] = st.pc + PC_W'(1); // RULE5
                    next_st.sp = st.sp + SP_W'(1);
                    next_st.pc = instr_target_i; // RULE5 RULE20
                end
                OP_CLR_BYTE: next_st.mem[instr_addr_i] = 8'h00; // RULE6
                OP_CLR_BIT: next_st.mem[instr_addr_i][instr_bit_i] = 1'b0; // RULE7
                OP_DOG_CLEAR: begin
                    next_st.dog = '0; // RULE8
                    next_st.flags[FLAG_PD] = 1'b0; // RULE8
                    next_st.flags[FLAG_TO] = 1'b0; // RULE8
                    next_st.pre1 = 1'b0;
                    next_st.pre2 = 1'b0;
                end
                OP_DOG_PRECLEAR_FIRST, OP_DOG_PRECLEAR_SECOND: begin
                    if ((instr_op_i == OP_DOG_PRECLEAR_FIRST) ? st.pre2 : st.pre1) begin
                        next_st.dog = '0; // RULE9
                        next_st.flags[FLAG_PD] = 1'b0; // RULE9
                        next_st.flags[FLAG_TO] = 1'b0; // RULE9
                        next_st.pre1 = 1'b0;
                        next_st.pre2 = 1'b0;
                    end else if (instr_op_i == OP_DOG_PRECLEAR_FIRST) begin
                        next_st.pre1 = 1'b1; // RULE9
                    end else begin
                        next_st.pre2 = 1'b1; // RULE9
                    end
                end
                OP_HALT: begin
                    next_st.run = 1'b0; // RULE17
                    next_st.dog = '0; // RULE18
                    next_st.flags[FLAG_PD] = 1'b1; // RULE18
                    next_st.flags[FLAG_TO] = 1'b0; // RULE18
                end
                default: next_st.pc = st.pc + PC_W'(1);
            endcase
        end
        // expiry after the instruction so its set beats a clear
        if (dog_expire) begin
            next_st.dog = '0;
            next_st.flags[FLAG_TO] = 1'b1;
            next_st.run = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            st <= '0;
            st.pc <= PC_RST;
            st.flags <= FLAGS_RST;
            st.run <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign instr_ready_o = st.run;
    assign work_register_o = st.work;
    assign flags_o = st.flags;
    assign pc_o = st.pc;
    assign pready_o = st.pready;
    assign pslverr_o = st.pslverr;
    assign prdata_o = st.prdata;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    AST_ADC_WORK: assert property (fire && instr_op_i == OP_ADC_MEM |=> // RULE1
        st.work == 8'($past(st.work) + $past(mem_rd) + 8'($past(st.flags[FLAG_C]))))
        else $error("carry add into work register wrong");
    AST_ADC_BYTE: assert property (fire && instr_op_i == OP_ADC_TO_BYTE |=> // RULE2
        st.mem[$past(instr_addr_i)] ==
        8'($past(st.work) + $past(mem_rd) + 8'($past(st.flags[FLAG_C]))) &&
        st.work == $past(st.work))
        else $error("carry add into byte wrong");
    AST_ADD_IMM: assert property (fire && instr_op_i == OP_ADD_IMM |=> // RULE3
        {st.flags[FLAG_C], st.work} == 9'({1'b0, $past(st.work)} + {1'b0, $past(instr_imm_i)}))
        else $error("immediate add or carry wrong");
    AST_AND_ZERO_ONLY: assert property (fire && instr_op_i == OP_AND_TO_BYTE |=> // RULE4
        st.flags[FLAG_C] == $past(st.flags[FLAG_C]) &&
        st.flags[FLAG_OV] == $past(st.flags[FLAG_OV]) &&
        st.flags[FLAG_Z] == ($past(st.work & mem_rd) == 8'h00))
        else $error("byte and touched wrong flags");
    AST_CALL_PUSH: assert property (fire && instr_op_i == OP_CALL |=> // RULE5
        st.pc == $past(instr_target_i) &&
        st.stack[$past(st.sp)] == PC_W'($past(st.pc) + PC_W'(1)))
        else $error("call did not push and jump");
    AST_CLR_BYTE: assert property (fire && instr_op_i == OP_CLR_BYTE |=> // RULE6
        st.mem[$past(instr_addr_i)] == 8'h00 && st.flags[3:0] == $past(st.flags[3:0]))
        else $error("byte clear wrong");
    AST_CLR_BIT: assert property (fire && instr_op_i == OP_CLR_BIT |=> // RULE7
        st.mem[$past(instr_addr_i)] == ($past(mem_rd) & ~(8'h01 << $past(instr_bit_i))))
        else $error("bit clear wrong");
    AST_DOG_CLEAR: assert property (fire && instr_op_i == OP_DOG_CLEAR && !dog_expire |=> // RULE8
        st.flags[FLAG_PD] == 1'b0 && st.flags[FLAG_TO] == 1'b0 && st.dog == '0)
        else $error("dog clear wrong");
    AST_PRECLEAR_HOLD: assert property (fire && instr_op_i == OP_DOG_PRECLEAR_FIRST // RULE9
        && !st.pre2 && !dog_expire |=> st.pre1 && $stable(st.flags))
        else $error("lone preclear changed flags");
    AST_INVERT: assert property (fire && instr_op_i == OP_INVERT_BYTE |=> // RULE10
        st.mem[$past(instr_addr_i)] == ~$past(mem_rd))
        else $error("invert byte wrong");
    AST_DAA_CARRY: assert property (fire && instr_op_i == OP_DECIMAL_ADJUST // RULE13
        && st.flags[FLAG_C] |=> st.flags[FLAG_C] && st.work == $past(st.work))
        else $error("bcd adjust lost carry or wrote work");
    AST_DEC_WORK: assert property (fire && instr_op_i == OP_DEC_TO_WORK |=> // RULE16
        st.work == 8'($past(mem_rd) - 8'h01) && st.mem[$past(instr_addr_i)] == $past(mem_rd))
        else $error("decrement into work wrong");
    AST_HALT: assert property (fire && instr_op_i == OP_HALT && !dog_expire |=> // RULE17
        !instr_ready_o && st.flags[FLAG_PD] && !st.flags[FLAG_TO]
        ##1 $stable(st.pc) && $stable(st.work))
        else $error("halt did not stop or set flags"); // RULE18

    COV_ADC_CHAIN: cover property (fire && instr_op_i == OP_ADD_MEM ##1
        fire && instr_op_i == OP_ADC_MEM);
    COV_PRECLEAR_PAIR: cover property (fire && instr_op_i == OP_DOG_PRECLEAR_FIRST ##[1:8]
        fire && instr_op_i == OP_DOG_PRECLEAR_SECOND);
    COV_HALT_WAKE: cover property (fire && instr_op_i == OP_HALT ##[1:20] instr_ready_o);
    COV_DAA_CARRY: cover property (fire && instr_op_i == OP_DECIMAL_ADJUST ##1 st.flags[FLAG_C]);
endmodule : emx_exec
`default_nettype wire

/* File: emx_feed.sv */
// instruction feeder model standing in for the fetch stage
`timescale 1ns/1ps
`default_nettype none
module emx_feed
    import emx_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic go_i,
    input wire emx_op_e op_i,
    input wire logic [MEM_ADDR_W-1:0] addr_i,
    input wire logic [PC_W-1:0] arg_i,
    input wire logic ready_i,
    output logic valid_o,
    output var emx_op_e op_o,
    output logic [MEM_ADDR_W-1:0] addr_o,
    output logic [PC_W-1:0] arg_o
);
    // held until taken; idle addr_o and arg_o flip every cycle so stale values never help
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            valid_o <= 1'b0;
            op_o <= OP_NOP;
            addr_o <= 7'h00;
            arg_o <= 11'h000;
        end else if (go_i) begin
            valid_o <= 1'b1;
            op_o <= op_i;
            addr_o <= addr_i;
            arg_o <= arg_i;
        end else if (!valid_o || ready_i) begin
            valid_o <= 1'b0;
            addr_o <= ~addr_o;
            arg_o <= ~arg_o;
        end
    end
endmodule : emx_feed
`default_nettype wire

/* File: emx_exec_tb.sv */
// self-checking bench of the execute unit
`timescale 1ns/1ps
`default_nettype none
module emx_exec_tb
    import emx_pkg::*;
;
    localparam int DOG_SIM = 400;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic go = 1'b0;
    emx_op_e op = OP_NOP;
    logic [6:0] addr = 7'h00;
    logic [10:0] arg = 11'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic valid, ready, pready, pslverr, ok, err;
    emx_op_e iop;
    logic [6:0] iaddr;
    logic [10:0] iarg, pc, px;
    logic [7:0] work;
    logic [5:0] flags;
    logic [31:0] prdata, rd;
    int bad_count = 0;
    int check_count = 0;

    always #5 clk_sys_i = ~clk_sys_i;

    emx_feed emx_feed_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .go_i(go), .op_i(op),
        .addr_i(addr), .arg_i(arg), .ready_i(ready), .valid_o(valid), .op_o(iop),
        .addr_o(iaddr), .arg_o(iarg));
    emx_exec #(.DOG_N(DOG_SIM)) emx_exec_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .instr_valid_i(valid), .instr_op_i(iop), .instr_addr_i(iaddr),
        .instr_imm_i(iarg[7:0]), .instr_bit_i(iarg[2:0]), .instr_target_i(iarg),
        .instr_ready_o(ready), .work_register_o(work), .flags_o(flags), .pc_o(pc),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pready_o(pready), .pslverr_o(pslverr), .prdata_o(prdata));

    task automatic final_report();
        $display("checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic issue(input emx_op_e o, input logic [6:0] a, input logic [10:0] x);
        @(posedge clk_sys_i);
        go <= 1'b1;
        op <= o;
        addr <= a;
        arg <= x;
        @(posedge clk_sys_i);
        go <= 1'b0;
    endtask : issue

    task automatic wait_taken(input int lim, output logic took);
        int n;
        took = 1'b0;
        for (n = 0; n < lim && !took; n++) begin
            @(posedge clk_sys_i);
            took = (valid === 1'b1) && (ready === 1'b1);
        end
        #1;
    endtask : wait_taken

    // one instruction, then work, flags and pc against expectations
    task automatic run(input emx_op_e o, input logic [6:0] a, input logic [10:0] x,
                       input logic [7:0] ew, input logic [5:0] ef);
        issue(o, a, x);
        wait_taken(8, ok);
        px = (o == OP_CALL) ? x : px + 11'h001;
        chk("taken", 32'(ok), 32'h1);
        chk("work", 32'(work), 32'(ew));
        chk("flags", 32'(flags), 32'(ef));
        chk("pc", 32'(pc), 32'(px));
    endtask : run

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk_sys_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
        chk("apb answer", 32'(n < 20), 32'h1);
    endtask : apb

    task automatic mchk(input logic [6:0] i, input logic [7:0] e);
        apb(1'b0, 12'h100 + {3'h0, i, 2'b00}, 32'h0);
        chk("byte", rd, {24'h0, e});
    endtask : mchk

    task automatic wake(input int lim);
        int n;
        for (n = 0; n < lim && ready !== 1'b1; n++) begin
            @(posedge clk_sys_i);
        end
        #1;
        chk("ready", 32'(ready), 32'h1);
    endtask : wake

    initial begin
        #300000;
        bad_count++;
        final_report();
    end

    initial begin
        repeat (12) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        px = PC_RST;
        #1;
        chk("ready", 32'(ready), 32'h1);
        chk("flags", 32'(flags), 32'(FLAGS_RST));
        chk("pc", 32'(pc), 32'(PC_RST));
        run(OP_AND_IMM, 7'h00, 11'h000, 8'h00, 6'h04);
        run(OP_ADD_IMM, 7'h00, 11'h07f, 8'h7f, 6'h00);
        run(OP_ADD_IMM, 7'h00, 11'h001, 8'h80, 6'h0a);
        run(OP_ADD_IMM, 7'h00, 11'h080, 8'h00, 6'h0d);
        run(OP_ADD_IMM, 7'h00, 11'h035, 8'h35, 6'h00);
        run(OP_ADD_TO_BYTE, 7'h05, 11'h000, 8'h35, 6'h00);
        mchk(7'h05, 8'h35);
        run(OP_ADD_IMM, 7'h00, 11'h0cb, 8'h00, 6'h07);
        run(OP_ADC_MEM, 7'h05, 11'h000, 8'h36, 6'h00);
        run(OP_ADD_IMM, 7'h00, 11'h0ff, 8'h35, 6'h03);
        run(OP_ADC_TO_BYTE, 7'h05, 11'h000, 8'h35, 6'h00);
        mchk(7'h05, 8'h6b);
        run(OP_ADD_IMM, 7'h00, 11'h003, 8'h38, 6'h00);
        run(OP_ADD_IMM, 7'h00, 11'h029, 8'h61, 6'h02);
        run(OP_DECIMAL_ADJUST, 7'h06, 11'h000, 8'h61, 6'h02);
        mchk(7'h06, 8'h67);
        run(OP_ADD_IMM, 7'h00, 11'h039, 8'h9a, 6'h08);
        run(OP_DECIMAL_ADJUST, 7'h07, 11'h000, 8'h9a, 6'h09);
        mchk(7'h07, 8'h00);
        run(OP_AND_TO_BYTE, 7'h06, 11'h000, 8'h9a, 6'h09);
        mchk(7'h06, 8'h02);
        run(OP_AND_MEM, 7'h07, 11'h000, 8'h00, 6'h0d);
        run(OP_DECIMAL_ADJUST, 7'h08, 11'h000, 8'h00, 6'h0d);
        mchk(7'h08, 8'h60);
        run(OP_INVERT_BYTE, 7'h06, 11'h000, 8'h00, 6'h09);
        mchk(7'h06, 8'hfd);
        run(OP_INVERT_TO_WORK, 7'h06, 11'h000, 8'h02, 6'h09);
        mchk(7'h06, 8'hfd);
        run(OP_DEC_BYTE, 7'h07, 11'h000, 8'h02, 6'h09);
        mchk(7'h07, 8'hff);
        run(OP_DEC_TO_WORK, 7'h07, 11'h000, 8'hfe, 6'h09);
        mchk(7'h07, 8'hff);
        run(OP_INVERT_TO_WORK, 7'h07, 11'h000, 8'h00, 6'h0d);
        run(OP_CLR_BIT, 7'h06, 11'h002, 8'h00, 6'h0d);
        run(OP_CLR_BIT, 7'h06, 11'h007, 8'h00, 6'h0d);
        mchk(7'h06, 8'h79);
        run(OP_CLR_BYTE, 7'h06, 11'h000, 8'h00, 6'h0d);
        mchk(7'h06, 8'h00);
        run(OP_CALL, 7'h00, 11'h5a3, 8'h00, 6'h0d);
        run(OP_DOG_CLEAR, 7'h00, 11'h000, 8'h00, 6'h0d);
        run(OP_HALT, 7'h00, 11'h000, 8'h00, 6'h1d);
        chk("ready", 32'(ready), 32'h0);
        issue(OP_ADD_IMM, 7'h00, 11'h001);
        wait_taken(6, ok);
        chk("taken", 32'(ok), 32'h0);
        chk("work", 32'(work), 32'h0);
        apb(1'b1, REG_CTRL, 32'h1);
        wait_taken(10, ok);
        px = px + 11'h001;
        chk("taken", 32'(ok), 32'h1);
        chk("work", 32'(work), 32'h01);
        chk("flags", 32'(flags), 32'h10);
        mchk(7'h05, 8'h6b);
        run(OP_DOG_CLEAR, 7'h00, 11'h000, 8'h01, 6'h00);
        apb(1'b0, REG_DOG, 32'h0);
        chk("dog", 32'(rd < 32'd16), 32'h1);
        run(OP_HALT, 7'h00, 11'h000, 8'h01, 6'h10);
        wake(DOG_SIM + 50);
        chk("flags", 32'(flags), 32'h30);
        run(OP_DOG_PRECLEAR_FIRST, 7'h00, 11'h000, 8'h01, 6'h30);
        run(OP_DOG_PRECLEAR_FIRST, 7'h00, 11'h000, 8'h01, 6'h30);
        run(OP_DOG_PRECLEAR_SECOND, 7'h00, 11'h000, 8'h01, 6'h00);
        run(OP_HALT, 7'h00, 11'h000, 8'h01, 6'h10);
        apb(1'b1, REG_CTRL, 32'h1);
        wake(10);
        run(OP_DOG_PRECLEAR_SECOND, 7'h00, 11'h000, 8'h01, 6'h10);
        run(OP_DOG_PRECLEAR_FIRST, 7'h00, 11'h000, 8'h01, 6'h00);
        apb(1'b1, REG_WORK, 32'hff);
        apb(1'b0, REG_WORK, 32'h0);
        chk("work reg", rd, 32'h01);
        apb(1'b0, REG_PC, 32'h0);
        chk("pc reg", rd, 32'(px));
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped err", 32'(err), 32'h1);
        chk("unmapped data", rd, 32'h0);
        final_report();
    end
endmodule : emx_exec_tb
`default_nettype wire
